/* File: core/prs_pkg.sv */
// constants of the power and reset supervisor: offsets, field positions,
// reset values; assumes a 32-bit peripheral bus with byte offsets
package prs_pkg;
   localparam int PRS_ADDR_W = 12;
   localparam logic [11:0] PRS_OFS_ANALOG = 12'h000;
   localparam logic [11:0] PRS_OFS_STATUS = 12'h004;
   localparam logic [11:0] PRS_OFS_DETECT = 12'h008;
   localparam logic [11:0] PRS_OFS_BROWNOUT = 12'h00C;
   // mask byte to control byte layout of every register
   localparam int PRS_MASK_HI_LSB = 24;
   localparam int PRS_CTRL_HI_LSB = 16;
   localparam int PRS_MASK_LO_LSB = 8;
   localparam int PRS_CTRL_LO_LSB = 0;
   // compact control image: [15:8] = word bits 23:16, [7:0] = word bits 7:0
   localparam int PRS_A_REG_EN = 8;
   localparam int PRS_A_VSEL_LSB = 10;
   localparam int PRS_A_CMS = 5;
   localparam int PRS_A_BANDGAP = 4;
   localparam int PRS_A_PIN_EN = 1;
   localparam int PRS_A_CORE_LP = 0;
   localparam logic [15:0] PRS_A_WR_BITS = 16'h0D33;
   localparam logic [15:0] PRS_A_RESET = 16'h0000;
   localparam int PRS_D_THR_LSB = 4;
   localparam int PRS_D_EDGE = 3;
   localparam int PRS_D_REF = 2;
   localparam int PRS_D_INSEL = 1;
   localparam int PRS_D_EN = 0;
   localparam int PRS_D_OUT_BIT = 16;
   localparam logic [15:0] PRS_D_WR_BITS = 16'h00FF;
   localparam logic [15:0] PRS_D_RESET = 16'h0000;
   localparam int PRS_S_MODE = 4;
   localparam logic [15:0] PRS_S_WR_BITS = 16'h0010;
   localparam logic [15:0] PRS_S_RESET = 16'h0000;
   localparam int PRS_S_FLAGS = 4;
   localparam logic [3:0] PRS_S_FLAG_RESET = 4'h1;
   localparam int PRS_F_SLEEP = 3;
   localparam int PRS_F_WDT = 2;
   localparam int PRS_F_EXT = 1;
   localparam int PRS_F_BROWNOUT = 0;
   localparam int PRS_B_IRQ = 7;
   localparam int PRS_B_THR_LSB = 4;
   localparam int PRS_B_WAKE = 3;
   localparam int PRS_B_LEVEL = 2;
   localparam int PRS_B_MODE = 1;
   localparam int PRS_B_EN = 0;
   localparam logic [2:0] PRS_B_THR_LOWEST = 3'h0;
   localparam logic PRS_B_WAKE_RESET = 1'b1;
   localparam logic PRS_B_MODE_RESET = 1'b1;
   localparam logic PRS_B_EN_RESET = 1'b1;
endpackage

/* File: core/prs_mask_reg.sv */
// masked-write control register, compact 16-bit image of bits 23:16 and 7:0
// assumes one-cycle write strobe from the bus slave
`timescale 1ns/1ns
module prs_mask_reg
   import prs_pkg::*;
#(
   parameter logic [15:0] WR_BITS = 16'hFFFF,
   parameter logic [15:0] RESET = 16'h0000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr,
   input wire logic [31:0] wdata,
   output logic [15:0] q
);
   logic [15:0] mask;
   logic [15:0] data;
   assign mask = {wdata[PRS_MASK_HI_LSB +: 8], wdata[PRS_MASK_LO_LSB +: 8]};
   assign data = {wdata[PRS_CTRL_HI_LSB +: 8], wdata[PRS_CTRL_LO_LSB +: 8]};
   for (genvar i = 0; i < 16; i++) begin : g_bit
      if (WR_BITS[i]) begin : g_rw
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               q[i] <= RESET[i];
            end else if (wr && mask[i]) begin
               q[i] <= data[i];
            end
         end
      end else begin : g_ro
         assign q[i] = 1'b0;
      end
   end
endmodule

/* File: core/prs_flag_bank.sv */
// bank of sticky flags, a set in the clearing cycle wins
// assumes single-cycle set and clear pulses or levels
`timescale 1ns/1ns
module prs_flag_bank
   import prs_pkg::*;
#(
   parameter int N = 4,
   parameter logic [N-1:0] RESET = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [N-1:0] set,
   input wire logic [N-1:0] clr,
   output logic [N-1:0] q
);
   for (genvar i = 0; i < N; i++) begin : g_flag
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            q[i] <= RESET[i];
         end else if (set[i]) begin
            q[i] <= 1'b1;
         end else if (clr[i]) begin
            q[i] <= 1'b0;
         end
      end
   end
endmodule

/* File: core/prs_supervisor.sv */
// power management control and reset-cause status, register block on the
// peripheral bus; assumes detector and event inputs synchronous to CLK_SYS
// Summary of operation
// [R01] sleep/idle flag; cleared by brown-out or pin reset
// [R02] watchdog flag; cleared by brown-out or external reset
// [R03] external reset flag; only brown-out clears it
// [R04] brown-out flag; clears once supply recovered
// [R05] coarse trip resets chip, sets brown-out flag
// [R06] coarse detector always enabled
// [R07] coarse trip re-arms precise detector, lowest threshold
// [R08] precise detector: reset or interrupt flag
// [R09] precise enable cleared stops the detector
// [R10] wake auto-enable default on, forces reset mode
// [R11] wake auto-enable off keeps precise settings
// [R12] software enables bandgap before analog functions
// [R13] software picks internal or external common mode
// [R14] pin enable routes common-mode reference out
// [R15] software: threshold zero for external input
// [R16] software order: input, reference, threshold, enable
// [R17] detect reference select picks brown-out or bandgap
// [R18] two-bit analog supply level select
// [R19] analog regulator off means high impedance
// [R20] bandgap enable bit drives bandgap reference
// [R21] idle keeps coarse detector and core regulator
// [R22] mask bits gate writes, read as zero
// [R23] mode bit selects sleep or idle
`timescale 1ns/1ns
module prs_supervisor
   import prs_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [PRS_ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic LOWPOWER_ACTIVE,
   input wire logic WAKE_FROM_SLEEP,
   input wire logic WDT_EVENT,
   input wire logic RESET_PIN_EVENT,
   input wire logic PROG_PORT_RESET,
   input wire logic COARSE_BROWNOUT_TRIP,
   input wire logic PRECISE_BROWNOUT_TRIP,
   input wire logic PRECISE_BROWNOUT_LEVEL,
   input wire logic SUPPLY_RECOVERED,
   input wire logic DETECT_OUTPUT,
   output logic CHIP_RESET_REQ,
   output logic COARSE_BROWNOUT_EN,
   output logic PRECISE_BROWNOUT_EN,
   output logic PRECISE_BROWNOUT_RESET_MODE,
   output logic [2:0] PRECISE_BROWNOUT_THRESHOLD,
   output logic PRECISE_BROWNOUT_IRQ,
   output logic LOWPOWER_MODE_IDLE,
   output logic CORE_REGULATOR_EN,
   output logic CORE_REGULATOR_LOW_POWER,
   output logic ANALOG_REGULATOR_EN,
   output logic [1:0] ANALOG_SUPPLY_VOLTAGE_SELECT,
   output logic BANDGAP_EN,
   output logic COMMON_MODE_SOURCE_SELECT,
   output logic COMMON_MODE_PIN_EN,
   output logic DETECTOR_EN,
   output logic DETECT_INPUT_SELECT,
   output logic DETECT_REFERENCE_SELECT,
   output logic DETECT_IRQ_RISING,
   output logic [3:0] DETECT_THRESHOLD
);
   logic setup;
   logic wr;
   logic wr_analog;
   logic wr_status;
   logic wr_detect;
   logic wr_brownout;
   logic mapped;
   logic [15:0] analog_q;
   logic [15:0] detect_q;
   logic [15:0] status_q;
   logic [3:0] flags;
   logic [3:0] flag_set;
   logic [3:0] flag_clr;
   logic [7:0] wmask_lo;
   logic [7:0] wdata_lo;
   logic lv_reset;
   logic ext_reset;
   logic precise_irq_event;
   logic precise_en;
   logic precise_mode;
   logic [2:0] precise_thr;
   logic wake_en;
   logic precise_irq;
   logic [31:0] next_prdata;

   // bus slave: zero-wait, error on unmapped offsets
   assign setup = PSEL && !PENABLE;
   assign wr = PSEL && PENABLE && PWRITE;
   assign mapped = (PADDR == PRS_OFS_ANALOG) || (PADDR == PRS_OFS_STATUS) ||
      (PADDR == PRS_OFS_DETECT) || (PADDR == PRS_OFS_BROWNOUT);
   assign wr_analog = wr && (PADDR == PRS_OFS_ANALOG);
   assign wr_status = wr && (PADDR == PRS_OFS_STATUS);
   assign wr_detect = wr && (PADDR == PRS_OFS_DETECT);
   assign wr_brownout = wr && (PADDR == PRS_OFS_BROWNOUT);
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !mapped;
   assign wmask_lo = PWDATA[PRS_MASK_LO_LSB +: 8];
   assign wdata_lo = PWDATA[PRS_CTRL_LO_LSB +: 8];

   // masked control registers
   prs_mask_reg #(.WR_BITS(PRS_A_WR_BITS), .RESET(PRS_A_RESET)) u_analog (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .wr(wr_analog), // R22
      .wdata(PWDATA),
      .q(analog_q)
   );
   prs_mask_reg #(.WR_BITS(PRS_D_WR_BITS), .RESET(PRS_D_RESET)) u_detect (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .wr(wr_detect), // R22
      .wdata(PWDATA),
      .q(detect_q)
   );
   prs_mask_reg #(.WR_BITS(PRS_S_WR_BITS), .RESET(PRS_S_RESET)) u_status (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .wr(wr_status), // R22
      .wdata(PWDATA),
      .q(status_q)
   );

   // reset causes
   assign precise_irq_event = PRECISE_BROWNOUT_TRIP && precise_en && !precise_mode; // R08
   assign lv_reset = COARSE_BROWNOUT_TRIP || (PRECISE_BROWNOUT_TRIP && precise_en && precise_mode); // R05 R08 R09
   assign ext_reset = RESET_PIN_EVENT || PROG_PORT_RESET;
   assign flag_set[PRS_F_SLEEP] = LOWPOWER_ACTIVE; // R01
   assign flag_clr[PRS_F_SLEEP] = lv_reset || RESET_PIN_EVENT; // R01
   assign flag_set[PRS_F_WDT] = WDT_EVENT; // R02
   assign flag_clr[PRS_F_WDT] = lv_reset || ext_reset; // R02
   assign flag_set[PRS_F_EXT] = ext_reset; // R03
   assign flag_clr[PRS_F_EXT] = lv_reset; // R03
   assign flag_set[PRS_F_BROWNOUT] = lv_reset; // R04 R05
   assign flag_clr[PRS_F_BROWNOUT] = SUPPLY_RECOVERED; // R04

   prs_flag_bank #(.N(PRS_S_FLAGS), .RESET(PRS_S_FLAG_RESET)) u_flags (
      .clk(CLK_SYS),
      .rst_n(RESETN),
      .set(flag_set),
      .clr(flag_clr),
      .q(flags)
   );

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         CHIP_RESET_REQ <= 1'b0;
      end else begin
         CHIP_RESET_REQ <= lv_reset; // R05 R08
      end
   end

   // precise detector control, hardware events override software
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         precise_en <= PRS_B_EN_RESET;
         precise_mode <= PRS_B_MODE_RESET;
         precise_thr <= PRS_B_THR_LOWEST;
      end else if (COARSE_BROWNOUT_TRIP) begin
         precise_en <= 1'b1; // R07
         precise_mode <= 1'b1;
         precise_thr <= PRS_B_THR_LOWEST; // R07
      end else if (WAKE_FROM_SLEEP && wake_en) begin
         precise_en <= 1'b1; // R10
         precise_mode <= 1'b1; // R10
      end else if (wr_brownout) begin
         if (wmask_lo[PRS_B_EN]) begin
            precise_en <= wdata_lo[PRS_B_EN]; // R09 R22
         end
         if (wmask_lo[PRS_B_MODE]) begin
            precise_mode <= wdata_lo[PRS_B_MODE]; // R08 R22
         end
         for (int i = 0; i < 3; i++) begin
            if (wmask_lo[PRS_B_THR_LSB + i]) begin
               precise_thr[i] <= wdata_lo[PRS_B_THR_LSB + i];
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         wake_en <= PRS_B_WAKE_RESET; // R10
      end else if (wr_brownout && wmask_lo[PRS_B_WAKE]) begin
         wake_en <= wdata_lo[PRS_B_WAKE]; // R11
      end
   end

   // interrupt flag: set wins, software writes zero to clear
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         precise_irq <= 1'b0;
      end else if (precise_irq_event) begin
         precise_irq <= 1'b1; // R08
      end else if (wr_brownout && wmask_lo[PRS_B_IRQ] && !wdata_lo[PRS_B_IRQ]) begin
         precise_irq <= 1'b0;
      end
   end

   // read data captured in the setup phase, mask bits read zero
   always_comb begin
      next_prdata = 32'h0000_0000;
      case (PADDR)
         PRS_OFS_ANALOG: begin
            next_prdata[PRS_CTRL_HI_LSB +: 8] = analog_q[15:8]; // R22
            next_prdata[PRS_CTRL_LO_LSB +: 8] = analog_q[7:0];
         end
         PRS_OFS_STATUS: begin
            next_prdata[PRS_CTRL_LO_LSB +: 8] = status_q[7:0];
            next_prdata[PRS_S_FLAGS-1:0] = flags;
         end
         PRS_OFS_DETECT: begin
            next_prdata[PRS_CTRL_LO_LSB +: 8] = detect_q[7:0];
            next_prdata[PRS_D_OUT_BIT] = DETECT_OUTPUT;
         end
         PRS_OFS_BROWNOUT: begin
            next_prdata[PRS_B_IRQ] = precise_irq;
            next_prdata[PRS_B_THR_LSB +: 3] = precise_thr;
            next_prdata[PRS_B_WAKE] = wake_en;
            next_prdata[PRS_B_LEVEL] = PRECISE_BROWNOUT_LEVEL;
            next_prdata[PRS_B_MODE] = precise_mode;
            next_prdata[PRS_B_EN] = precise_en;
         end
         default: begin
            next_prdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         PRDATA <= 32'h0000_0000;
      end else if (setup && !PWRITE) begin
         PRDATA <= next_prdata;
      end
   end

   // control outputs
   assign COARSE_BROWNOUT_EN = 1'b1; // R06 R21
   assign CORE_REGULATOR_EN = 1'b1; // R21
   assign LOWPOWER_MODE_IDLE = status_q[PRS_S_MODE]; // R23
   // low-power core regulator only in sleep, never in idle
   assign CORE_REGULATOR_LOW_POWER = analog_q[PRS_A_CORE_LP] && LOWPOWER_ACTIVE &&
      !status_q[PRS_S_MODE]; // R21
   assign PRECISE_BROWNOUT_EN = precise_en; // R09
   assign PRECISE_BROWNOUT_RESET_MODE = precise_mode;
   assign PRECISE_BROWNOUT_THRESHOLD = precise_thr;
   assign PRECISE_BROWNOUT_IRQ = precise_irq;
   assign ANALOG_REGULATOR_EN = analog_q[PRS_A_REG_EN]; // R19
   assign ANALOG_SUPPLY_VOLTAGE_SELECT = analog_q[PRS_A_VSEL_LSB +: 2]; // R18
   assign BANDGAP_EN = analog_q[PRS_A_BANDGAP]; // R20
   assign COMMON_MODE_SOURCE_SELECT = analog_q[PRS_A_CMS];
   assign COMMON_MODE_PIN_EN = analog_q[PRS_A_PIN_EN]; // R14
   assign DETECTOR_EN = detect_q[PRS_D_EN];
   assign DETECT_INPUT_SELECT = detect_q[PRS_D_INSEL];
   assign DETECT_REFERENCE_SELECT = detect_q[PRS_D_REF]; // R17
   assign DETECT_IRQ_RISING = detect_q[PRS_D_EDGE];
   assign DETECT_THRESHOLD = detect_q[PRS_D_THR_LSB +: 4];

   // checks
   sequence s_coarse_trip;
      COARSE_BROWNOUT_TRIP;
   endsequence
   sequence s_rearmed;
      PRECISE_BROWNOUT_EN && PRECISE_BROWNOUT_RESET_MODE && (PRECISE_BROWNOUT_THRESHOLD == 3'h0);
   endsequence
   sequence s_wake_force;
      WAKE_FROM_SLEEP && wake_en && !COARSE_BROWNOUT_TRIP;
   endsequence

   a_coarse_rearm: // R07
   assert property (@(posedge CLK_SYS) disable iff (!RESETN) s_coarse_trip |=> s_rearmed)
      else $error("precise detector not re-armed after coarse trip");
   a_coarse_reset: // R05
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      s_coarse_trip |=> CHIP_RESET_REQ && flags[PRS_F_BROWNOUT])
      else $error("coarse trip did not reset or flag");
   a_precise_irq: // R08
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      PRECISE_BROWNOUT_TRIP && PRECISE_BROWNOUT_EN && !PRECISE_BROWNOUT_RESET_MODE && !COARSE_BROWNOUT_TRIP
      |=> PRECISE_BROWNOUT_IRQ && !CHIP_RESET_REQ)
      else $error("interrupt mode trip handled wrongly");
   a_wake_force: // R10
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      s_wake_force |=> PRECISE_BROWNOUT_EN && PRECISE_BROWNOUT_RESET_MODE)
      else $error("wake did not force precise reset mode");
   a_wake_keep: // R11
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      WAKE_FROM_SLEEP && !wake_en && !COARSE_BROWNOUT_TRIP && !wr_brownout
      |=> $stable(PRECISE_BROWNOUT_EN) && $stable(PRECISE_BROWNOUT_RESET_MODE))
      else $error("wake changed precise settings");
   a_mask_gate: // R22
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      wr_analog && (PWDATA[31:24] == 8'h00) && (PWDATA[15:8] == 8'h00) |=> $stable(analog_q))
      else $error("unmasked write changed a control bit");
   a_ext_flag: // R03
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      ext_reset ##1 !lv_reset [*2] |=> flags[PRS_F_EXT])
      else $error("external reset flag lost");
   a_sleep_flag: // R01
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      LOWPOWER_ACTIVE |=> flags[PRS_F_SLEEP])
      else $error("sleep flag not set");
   a_wdt_clear: // R02
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      ext_reset && !WDT_EVENT |=> !flags[PRS_F_WDT])
      else $error("watchdog flag not cleared");
   a_bo_clear: // R04
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      SUPPLY_RECOVERED && !lv_reset |=> !flags[PRS_F_BROWNOUT])
      else $error("brown-out flag not cleared on recovery");
   a_precise_reset: // R08
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      PRECISE_BROWNOUT_TRIP && PRECISE_BROWNOUT_EN && PRECISE_BROWNOUT_RESET_MODE
      |=> CHIP_RESET_REQ && flags[PRS_F_BROWNOUT])
      else $error("reset mode trip did not reset");
   a_precise_off: // R09
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      PRECISE_BROWNOUT_TRIP && !PRECISE_BROWNOUT_EN && !COARSE_BROWNOUT_TRIP && !wr_brownout
      |=> !CHIP_RESET_REQ && $stable(PRECISE_BROWNOUT_IRQ))
      else $error("disabled precise detector acted");
   a_irq_clear: // R08
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      wr_brownout && wmask_lo[PRS_B_IRQ] && !wdata_lo[PRS_B_IRQ] && !precise_irq_event |=> !PRECISE_BROWNOUT_IRQ)
      else $error("interrupt flag not cleared");
   a_mode_select: // R23
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      wr_status && wmask_lo[PRS_S_MODE] |=> LOWPOWER_MODE_IDLE == $past(wdata_lo[PRS_S_MODE]))
      else $error("mode bit not written");
   a_read_mask: // R22
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      (PRDATA[31:24] == 8'h00) && (PRDATA[15:8] == 8'h00))
      else $error("mask bits read back nonzero");
   a_sleep_clear: // R01
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      RESET_PIN_EVENT && !LOWPOWER_ACTIVE |=> !flags[PRS_F_SLEEP])
      else $error("sleep flag not cleared");
   a_ext_clear: // R03
   assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      lv_reset && !ext_reset |=> !flags[PRS_F_EXT])
      else $error("external reset flag not cleared");
endmodule

/* File: dv/tb_top.sv */
// self-checking bench of the power and reset supervisor, model in integers
// assumes prs_pkg and the core files are compiled before it
`timescale 1ns/1ns
module tb_top
   import prs_pkg::*;
();
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [9:0] ev = 10'h000;
   wire [24:0] o;
   int m_ana, m_st, m_det, m_bo, m_fl;
   bit m_crr;
   int bad_count = 0;
   int checks_done = 0;

   always #5 clk_sys = ~clk_sys;

   prs_supervisor u_prs_supervisor (.CLK_SYS(clk_sys), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .LOWPOWER_ACTIVE(ev[0]), .WAKE_FROM_SLEEP(ev[1]), .WDT_EVENT(ev[2]), .RESET_PIN_EVENT(ev[3]),
      .PROG_PORT_RESET(ev[4]), .COARSE_BROWNOUT_TRIP(ev[5]), .PRECISE_BROWNOUT_TRIP(ev[6]),
      .SUPPLY_RECOVERED(ev[7]), .PRECISE_BROWNOUT_LEVEL(ev[8]), .DETECT_OUTPUT(ev[9]),
      .CHIP_RESET_REQ(o[0]), .COARSE_BROWNOUT_EN(o[1]), .PRECISE_BROWNOUT_EN(o[2]),
      .PRECISE_BROWNOUT_RESET_MODE(o[3]), .PRECISE_BROWNOUT_THRESHOLD(o[6:4]), .PRECISE_BROWNOUT_IRQ(o[7]),
      .LOWPOWER_MODE_IDLE(o[8]), .CORE_REGULATOR_EN(o[9]), .CORE_REGULATOR_LOW_POWER(o[10]),
      .ANALOG_REGULATOR_EN(o[11]), .ANALOG_SUPPLY_VOLTAGE_SELECT(o[13:12]), .BANDGAP_EN(o[14]),
      .COMMON_MODE_SOURCE_SELECT(o[15]), .COMMON_MODE_PIN_EN(o[16]), .DETECTOR_EN(o[17]),
      .DETECT_INPUT_SELECT(o[18]), .DETECT_REFERENCE_SELECT(o[19]), .DETECT_IRQ_RISING(o[20]),
      .DETECT_THRESHOLD(o[24:21]));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // masked write of one register image
   function automatic int mw(input int old, input logic [31:0] d, input int wr_bits);
      int m;
      m = {8'h00, d[31:24], 8'h00, d[15:8]} & wr_bits;
      return (old & ~m) | (d & m);
   endfunction

   task automatic chk_out();
      logic [24:0] e;
      e = {m_det[7:0], m_ana[1], m_ana[5], m_ana[4], m_ana[19:18], m_ana[16], m_ana[0] & ev[0] & !m_st[4],
         1'b1, m_st[4], m_bo[7:4], m_bo[1:0], 1'b1, m_crr};
      chk({7'h00, o}, {7'h00, e}, "control outputs");
   endtask

   // one bus transfer, three cycles, checked in the access phase
   task automatic xfer(input bit wr, input logic [11:0] a, input logic [31:0] d);
      logic [31:0] er;
      bit un;
      un = 0;
      case (a)
         PRS_OFS_ANALOG: er = m_ana;
         PRS_OFS_STATUS: er = m_st | m_fl;
         PRS_OFS_DETECT: er = m_det | {ev[9], 16'h0000};
         PRS_OFS_BROWNOUT: er = m_bo | {ev[8], 2'b00};
         default: begin
            er = 32'h00000000;
            un = 1;
         end
      endcase
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      chk(pready, 1, "ready");
      chk(pslverr, un, "slave error");
      if (!wr) chk(prdata, er, "read data");
      psel <= 1'b0;
      penable <= 1'b0;
      if (wr && !un) begin
         case (a)
            PRS_OFS_ANALOG: m_ana = mw(m_ana, d, 32'h000D0033);
            PRS_OFS_STATUS: m_st = mw(m_st, d, 32'h00000010);
            PRS_OFS_DETECT: m_det = mw(m_det, d, 32'h000000FF);
            default: begin
               m_bo = mw(m_bo, d, 32'h0000007B);
               if (d[15] && !d[7]) m_bo[7] = 0;
            end
         endcase
         #1 chk_out();
      end
   endtask

   // event pulses: 0 lowpower 1 wake 2 wdt 3 pin 4 prog 5 coarse 6 precise 7 recovered
   task automatic step(input logic [7:0] b);
      bit lv;
      @(posedge clk_sys);
      ev[7:0] <= b;
      ev[9:8] <= 2'($urandom);
      #1 chk_out();
      @(posedge clk_sys);
      ev[7:0] <= 8'h00;
      lv = b[5] | (b[6] & m_bo[0] & m_bo[1]);
      m_fl[3] = b[0] | (m_fl[3] & !(lv | b[3]));
      m_fl[2] = b[2] | (m_fl[2] & !(lv | b[3] | b[4]));
      m_fl[1] = b[3] | b[4] | (m_fl[1] & !lv);
      m_fl[0] = lv | (m_fl[0] & !b[7]);
      m_bo[7] = m_bo[7] | (b[6] & m_bo[0] & !m_bo[1]);
      if (b[5]) begin
         m_bo[6:4] = 3'h0;
         m_bo[1:0] = 2'b11;
      end else if (b[1] && m_bo[3]) begin
         m_bo[1:0] = 2'b11;
      end
      m_crr = lv;
      #1 chk_out();
      m_crr = 0;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      tally_and_finish();
   end

   initial begin
      logic [7:0] b;
      void'($urandom(29549));
      m_ana = 0;
      m_st = 0;
      m_det = 0;
      m_bo = 32'h0B;
      m_fl = 1;
      m_crr = 0;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      for (int i = 0; i < 5; i++) xfer(0, 12'(i * 4), 32'h0);
      xfer(1, PRS_OFS_ANALOG, 32'h00FF00FF);
      xfer(1, PRS_OFS_ANALOG, 32'h00001010);
      for (int v = 0; v < 4; v++) xfer(1, PRS_OFS_ANALOG, 32'h0D010000 | (v << 18));
      xfer(1, PRS_OFS_ANALOG, 32'h00002323);
      xfer(1, PRS_OFS_ANALOG, 32'h01000000);
      xfer(1, PRS_OFS_DETECT, 32'h00000202);
      xfer(1, PRS_OFS_DETECT, 32'h00000404);
      xfer(1, PRS_OFS_DETECT, 32'h0000F050);
      xfer(1, PRS_OFS_DETECT, 32'h00000101);
      xfer(1, PRS_OFS_STATUS, 32'h00001010);
      step(8'h01);
      xfer(1, PRS_OFS_STATUS, 32'h00001000);
      step(8'h01);
      step(8'h04);
      step(8'h08);
      step(8'h14);
      step(8'h80);
      step(8'h20);
      xfer(1, PRS_OFS_BROWNOUT, 32'h00007371);
      step(8'h40);
      xfer(0, PRS_OFS_BROWNOUT, 32'h0);
      xfer(1, PRS_OFS_BROWNOUT, 32'h00008000);
      step(8'h02);
      xfer(1, PRS_OFS_BROWNOUT, 32'h00000900);
      step(8'h02);
      step(8'h40);
      step(8'h20);
      step(8'h40);
      xfer(0, PRS_OFS_STATUS, 32'h0);
      for (int n = 0; n < 300; n++) begin
         b = 8'($urandom & $urandom & $urandom);
         case ($urandom % 3)
            0: xfer(1, 12'(($urandom % 5) * 4), $urandom);
            1: xfer(0, 12'(($urandom % 5) * 4), 32'h0);
            default: step(b);
         endcase
      end
      tally_and_finish();
   end
endmodule
